// ==== shared/boe_consts.svh ====
// Constants for the byte-op / branch execute block.
// Assumes inclusion from the package and the execute module only.
`ifndef BOE_CONSTS_SVH
`define BOE_CONSTS_SVH
`define BOE_ZERO_BYTE 8'h00
`define BOE_ONE_BYTE 8'h01
`define BOE_DEST_ACCUM 1'h0
`define BOE_DEST_FILE 1'h1
`define BOE_PAGE_HI 6
`define BOE_PAGE_LO 5
`define BOE_IMM_W 9
`define BOE_PC_W 11
`endif

// ==== shared/boe_pkg.sv ====
// Types for the byte-op / branch execute block.
// Assumes the constants header is on the include path.
`default_nettype none
`include "boe_consts.svh"
package boe_pkg;
  typedef enum logic [3:0] {
    BOE_OP_NONE,
    BOE_OP_CLEAR_FILE_REG,
    BOE_OP_INVERT_FILE_REG,
    BOE_OP_MINUS_ONE_FILE_REG,
    BOE_OP_MINUS_ONE_SKIP_NULL,
    BOE_OP_PLUS_ONE_FILE_REG,
    BOE_OP_PLUS_ONE_SKIP_NULL,
    BOE_OP_OR_LITERAL_ACCUM,
    BOE_OP_JUMP_IMMEDIATE
  } boe_op_t;

  // One decoded instruction presented for execution
  typedef struct packed {
    boe_op_t op;
    logic dest;
    logic [7:0] literal;
    logic [8:0] target;
  } boe_instr_t;

  // Write-back and flow results
  typedef struct packed {
    logic accum_we;
    logic file_we;
    logic [7:0] data;
    logic zero_we;
    logic zero_val;
    logic pc_we;
    logic [10:0] pc;
    logic squash_next;
  } boe_result_t;
endpackage
`default_nettype wire

// ==== logic/boe_execute.sv ====
// Execute stage for clear/invert/inc/dec file ops, OR literal and jump.
// Assumes the core fetches one instruction ahead and applies results
// on the cycle after the instruction is presented with valid high.
// Only the zero flag is produced; other status bits stay with the core.
//
// Functional notes
// RL1: Clear writes zero to file, sets zero flag
// RL2: Destination bit 0 accumulator, 1 file register
// RL3: Invert file byte, route, update zero flag
// RL4: Decrement file byte, route, update zero flag
// RL5: Increment file byte, route, update zero flag
// RL6: Decrement-skip routes result, flags untouched
// RL7: Increment-skip routes result, flags untouched, tests zero
// RL8: Zero skip result discards fetched next instruction
// RL9: Jump loads nine-bit target plus page bits
// RL10: Jump takes two cycles, flags untouched
// RL11: OR literal into accumulator, update zero flag
// RL12: Zero flag means byte zero; wrap mod 256
`timescale 1ns/1ns
`default_nettype none
`include "boe_consts.svh"

module boe_execute
  import boe_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // Instruction and operands
  input wire logic instr_valid_i,
  input wire boe_instr_t instr_i,
  input wire logic [7:0] file_data_i,
  input wire logic [7:0] accum_i,
  input wire logic [7:0] status_i,
  // Results
  output boe_result_t result_o,
  output logic busy_o
);

  ////////////////////////////////////////////////////////////////////
  boe_result_t res_d;
  boe_result_t res_q;
  logic flush_d;
  logic flush_q;
  logic [7:0] value;
  // Low in the slot dropped after a skip or jump
  logic slot_live;

  function automatic logic is_null(input logic [7:0] v);
    is_null = (v == `BOE_ZERO_BYTE); // RL12
  endfunction

  // Byte ops whose result follows the destination select
  function automatic logic routes_by_dest(input boe_op_t op);
    routes_by_dest = op inside {BOE_OP_INVERT_FILE_REG, BOE_OP_MINUS_ONE_FILE_REG,
      BOE_OP_PLUS_ONE_FILE_REG, BOE_OP_MINUS_ONE_SKIP_NULL, BOE_OP_PLUS_ONE_SKIP_NULL}; // RL2
  endfunction

  assign slot_live = instr_valid_i && !flush_q;

  always_comb begin
    res_d = '0;
    value = `BOE_ZERO_BYTE;
    flush_d = 1'b0;
    // Instruction slot after a skip or jump is a forced no-op
    if (slot_live) begin
      unique case (instr_i.op)
        BOE_OP_CLEAR_FILE_REG: begin
          value = `BOE_ZERO_BYTE; // RL1
          res_d.file_we = 1'b1; // RL1
          res_d.zero_we = 1'b1;
          res_d.zero_val = 1'b1; // RL1
        end
        BOE_OP_INVERT_FILE_REG: begin
          value = ~file_data_i; // RL3
          res_d.zero_we = 1'b1;
          res_d.zero_val = is_null(value); // RL3
        end
        BOE_OP_MINUS_ONE_FILE_REG: begin
          value = file_data_i - `BOE_ONE_BYTE; // RL4 RL12
          res_d.zero_we = 1'b1;
          res_d.zero_val = is_null(value); // RL4
        end
        BOE_OP_PLUS_ONE_FILE_REG: begin
          value = file_data_i + `BOE_ONE_BYTE; // RL5 RL12
          res_d.zero_we = 1'b1;
          res_d.zero_val = is_null(value); // RL5
        end
        BOE_OP_MINUS_ONE_SKIP_NULL: begin
          value = file_data_i - `BOE_ONE_BYTE; // RL6
          res_d.squash_next = is_null(value); // RL8
        end
        BOE_OP_PLUS_ONE_SKIP_NULL: begin
          value = file_data_i + `BOE_ONE_BYTE; // RL7
          res_d.squash_next = is_null(value); // RL7 RL8
        end
        BOE_OP_OR_LITERAL_ACCUM: begin
          value = accum_i | instr_i.literal; // RL11
          res_d.accum_we = 1'b1;
          res_d.zero_we = 1'b1;
          res_d.zero_val = is_null(value); // RL11
        end
        BOE_OP_JUMP_IMMEDIATE: begin
          res_d.pc_we = 1'b1;
          res_d.pc = {status_i[`BOE_PAGE_HI:`BOE_PAGE_LO], instr_i.target}; // RL9
          res_d.squash_next = 1'b1; // RL10
        end
        default: begin
        end
      endcase
      // Destination routing for ops with a dest bit
      if (routes_by_dest(instr_i.op)) begin
        res_d.accum_we = (instr_i.dest == `BOE_DEST_ACCUM); // RL2
        res_d.file_we = (instr_i.dest == `BOE_DEST_FILE); // RL2
      end
      res_d.data = value;
      flush_d = res_d.squash_next;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      res_q <= '0;
      flush_q <= 1'b0;
    end else begin
      res_q <= res_d;
      flush_q <= flush_d;
    end
  end

  assign result_o = res_q;
  // Second cycle of a skip or jump
  assign busy_o = flush_q;

  ////////////////////////////////////////////////////////////////////
  // Result checks land one cycle after the edge that takes the slot
  sequence s_skip_hit;
    slot_live && instr_i.op == BOE_OP_PLUS_ONE_SKIP_NULL && file_data_i == 8'hFF;
  endsequence

  sequence s_dskip_hit;
    slot_live && instr_i.op == BOE_OP_MINUS_ONE_SKIP_NULL && file_data_i == 8'h01;
  endsequence

  // Dropped slot: no write-back and flow free again
  sequence s_slot_quiet;
    (result_o == '0) && !busy_o;
  endsequence

  chk_reset_quiet: assert property (@(posedge mclk_i)
    sys_rst_i |=> s_slot_quiet)
    else $error("reset left a result active");

  chk_clear_sets_zero: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // RL1
    slot_live && instr_i.op == BOE_OP_CLEAR_FILE_REG |=>
    result_o.file_we && !result_o.accum_we && result_o.zero_we && result_o.zero_val
      && result_o.data == 8'h00)
    else $error("clear did not zero file and set flag");

  chk_dest_routing: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // RL2
    slot_live && routes_by_dest(instr_i.op) |=>
    result_o.accum_we == !$past(instr_i.dest) && result_o.file_we == $past(instr_i.dest))
    else $error("destination routing wrong");

  chk_invert_value: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // RL3
    slot_live && instr_i.op == BOE_OP_INVERT_FILE_REG |=>
    result_o.data == ~$past(file_data_i) && result_o.zero_we)
    else $error("invert result wrong");

  chk_dec_value: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // RL4
    slot_live && instr_i.op == BOE_OP_MINUS_ONE_FILE_REG |=>
    result_o.data == $past(file_data_i) - 8'h01 && result_o.zero_we)
    else $error("decrement result wrong");

  chk_inc_value: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // RL5
    slot_live && instr_i.op == BOE_OP_PLUS_ONE_FILE_REG |=>
    result_o.data == $past(file_data_i) + 8'h01 && result_o.zero_we)
    else $error("increment result wrong");

  chk_dskip_flags: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // RL6
    slot_live && instr_i.op == BOE_OP_MINUS_ONE_SKIP_NULL |=>
    !result_o.zero_we && result_o.data == $past(file_data_i) - 8'h01)
    else $error("decrement-skip touched flags");

  chk_iskip_flags: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // RL7
    slot_live && instr_i.op == BOE_OP_PLUS_ONE_SKIP_NULL |=>
    !result_o.zero_we && result_o.data == $past(file_data_i) + 8'h01)
    else $error("increment-skip touched flags");

  chk_skip_squash: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // RL7 RL8
    s_skip_hit |=> result_o.squash_next && !result_o.zero_we && busy_o ##1
    s_slot_quiet)
    else $error("skip did not squash next slot");

  chk_dskip_squash: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // RL6 RL8
    s_dskip_hit |=> result_o.squash_next && busy_o ##1 s_slot_quiet)
    else $error("decrement-skip did not squash next slot");

  chk_skip_miss: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // RL8
    slot_live && instr_i.op == BOE_OP_PLUS_ONE_SKIP_NULL && file_data_i != 8'hFF |=>
    !result_o.squash_next && !busy_o)
    else $error("non-zero skip result dropped a slot");

  // Whatever the dropped slot holds, it must leave no trace
  chk_drop_slot: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // RL8
    flush_q |=> s_slot_quiet)
    else $error("dropped slot produced a result");

  chk_jump_target: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // RL9 RL10
    slot_live && instr_i.op == BOE_OP_JUMP_IMMEDIATE |=>
    result_o.pc == {$past(status_i[6:5]), $past(instr_i.target)} && busy_o)
    else $error("jump target or timing wrong");

  chk_jump_quiet: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // RL10
    slot_live && instr_i.op == BOE_OP_JUMP_IMMEDIATE |=>
    !result_o.zero_we && !result_o.accum_we && !result_o.file_we ##1 s_slot_quiet)
    else $error("jump touched flags or data");

  chk_or_zero: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // RL11 RL12
    slot_live && instr_i.op == BOE_OP_OR_LITERAL_ACCUM |=>
    result_o.accum_we && result_o.zero_we
      && result_o.data == ($past(accum_i) | $past(instr_i.literal))
      && result_o.zero_val == (result_o.data == 8'h00))
    else $error("or literal result or zero flag wrong");

  chk_zero_flag: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // RL12
    result_o.zero_we |-> result_o.zero_val == (result_o.data == 8'h00))
    else $error("zero flag disagrees with result byte");

endmodule
`default_nettype wire

// ==== testbench/byte_op_branch_execute_tb.sv ====
// Self-checking bench for the byte-op / branch execute stage.
// Assumes boe_pkg is compiled first; drives inputs on falling edges.
`timescale 1ns/1ns
`default_nettype none
module byte_op_branch_execute_tb;
  import boe_pkg::*;
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic instr_valid_i = 1'b0;
  boe_instr_t instr_i = '0;
  logic [7:0] file_data_i = 8'h00;
  logic [7:0] accum_i = 8'h00;
  logic [7:0] status_i = 8'h00;
  boe_result_t result_o;
  logic busy_o;
  int fail_count = 0;
  int n_compared = 0;
  boe_execute dut_u (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .instr_valid_i(instr_valid_i),
    .instr_i(instr_i), .file_data_i(file_data_i), .accum_i(accum_i), .status_i(status_i),
    .result_o(result_o), .busy_o(busy_o));
  initial begin
    forever #5 mclk_i = ~mclk_i;
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic boe_result_t mk(logic aw, logic fw, logic [7:0] d, logic zw, logic zv,
                                     logic pw, logic [10:0] pc, logic sq);
    return {aw, fw, d, zw, zv, pw, pc, sq};
  endfunction
  // Fields without their write strobe carry no meaning, so they are masked
  function automatic boe_result_t msk(boe_result_t r);
    boe_result_t m;
    m = r;
    if (m.pc_we !== 1'b1) m.pc = 11'h000;
    if (m.zero_we !== 1'b1) m.zero_val = 1'b0;
    if (m.accum_we !== 1'b1 && m.file_we !== 1'b1) m.data = 8'h00;
    return m;
  endfunction
  task automatic step(boe_op_t op, logic d, logic [7:0] lit, logic [8:0] tgt, logic [7:0] f,
                      logic [7:0] a, logic [7:0] st, boe_result_t er, logic eb);
    instr_valid_i = 1'b1;
    instr_i = '{op: op, dest: d, literal: lit, target: tgt};
    file_data_i = f;
    accum_i = a;
    status_i = st;
    @(negedge mclk_i);
    n_compared += 2;
    if (msk(result_o) !== msk(er) || busy_o !== eb) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h/%h exp=%h/%h", $time, result_o, busy_o, er, eb);
    end
  endtask
  // File-register op; destination decides the strobe, clear always hits the file
  task automatic fop(boe_op_t op, logic d, logic [7:0] f, logic [7:0] r, logic zw, logic zv,
                     logic sq);
    logic clr;
    clr = (op == BOE_OP_CLEAR_FILE_REG);
    step(op, d, 8'h00, 9'h000, f, 8'hC3, 8'h00,
         mk(!d && !clr, d || clr, r, zw, zv, 1'b0, 11'h000, sq), sq);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_byte_ops();
    fop(BOE_OP_CLEAR_FILE_REG, 1'b0, 8'h5A, 8'h00, 1'b1, 1'b1, 1'b0);
    fop(BOE_OP_INVERT_FILE_REG, 1'b0, 8'hFF, 8'h00, 1'b1, 1'b1, 1'b0);
    fop(BOE_OP_INVERT_FILE_REG, 1'b1, 8'h0F, 8'hF0, 1'b1, 1'b0, 1'b0);
    fop(BOE_OP_MINUS_ONE_FILE_REG, 1'b1, 8'h01, 8'h00, 1'b1, 1'b1, 1'b0);
    fop(BOE_OP_MINUS_ONE_FILE_REG, 1'b0, 8'h00, 8'hFF, 1'b1, 1'b0, 1'b0);
    fop(BOE_OP_PLUS_ONE_FILE_REG, 1'b0, 8'hFF, 8'h00, 1'b1, 1'b1, 1'b0);
    fop(BOE_OP_PLUS_ONE_FILE_REG, 1'b1, 8'h7F, 8'h80, 1'b1, 1'b0, 1'b0);
    $display("test byte_ops done");
  endtask
  task automatic t_skips();
    fop(BOE_OP_MINUS_ONE_SKIP_NULL, 1'b0, 8'h02, 8'h01, 1'b0, 1'b0, 1'b0);
    fop(BOE_OP_MINUS_ONE_SKIP_NULL, 1'b1, 8'h01, 8'h00, 1'b0, 1'b0, 1'b1);
    step(BOE_OP_OR_LITERAL_ACCUM, 1'b0, 8'h11, 9'h000, 8'h00, 8'h22, 8'h00, '0, 1'b0);
    fop(BOE_OP_PLUS_ONE_SKIP_NULL, 1'b0, 8'hFF, 8'h00, 1'b0, 1'b0, 1'b1);
    // Slot after a taken skip is dropped whatever it holds
    step(BOE_OP_CLEAR_FILE_REG, 1'b1, 8'h00, 9'h000, 8'h44, 8'h00, 8'h00, '0, 1'b0);
    fop(BOE_OP_PLUS_ONE_SKIP_NULL, 1'b1, 8'h10, 8'h11, 1'b0, 1'b0, 1'b0);
    fop(BOE_OP_PLUS_ONE_SKIP_NULL, 1'b1, 8'hFF, 8'h00, 1'b0, 1'b0, 1'b1);
    step(BOE_OP_JUMP_IMMEDIATE, 1'b0, 8'h00, 9'h155, 8'h00, 8'h00, 8'h60, '0, 1'b0);
    $display("test skips done");
  endtask
  task automatic t_or_jump();
    step(BOE_OP_OR_LITERAL_ACCUM, 1'b1, 8'h00, 9'h000, 8'hFF, 8'h00, 8'h00,
         mk(1'b1, 1'b0, 8'h00, 1'b1, 1'b1, 1'b0, 11'h000, 1'b0), 1'b0);
    step(BOE_OP_OR_LITERAL_ACCUM, 1'b0, 8'h05, 9'h000, 8'h00, 8'hA0, 8'h00,
         mk(1'b1, 1'b0, 8'hA5, 1'b1, 1'b0, 1'b0, 11'h000, 1'b0), 1'b0);
    step(BOE_OP_JUMP_IMMEDIATE, 1'b0, 8'h00, 9'h1AB, 8'h00, 8'h00, 8'h40,
         mk(1'b0, 1'b0, 8'h00, 1'b0, 1'b0, 1'b1, 11'h5AB, 1'b1), 1'b1);
    step(BOE_OP_JUMP_IMMEDIATE, 1'b0, 8'h00, 9'h0FF, 8'h00, 8'h00, 8'hBF, '0, 1'b0);
    step(BOE_OP_JUMP_IMMEDIATE, 1'b0, 8'h00, 9'h1FF, 8'h00, 8'h00, 8'h9F,
         mk(1'b0, 1'b0, 8'h00, 1'b0, 1'b0, 1'b1, 11'h1FF, 1'b1), 1'b1);
    step(BOE_OP_NONE, 1'b0, 8'h00, 9'h000, 8'h00, 8'h00, 8'h00, '0, 1'b0);
    $display("test or_jump done");
  endtask
  task automatic t_reset();
    step(BOE_OP_JUMP_IMMEDIATE, 1'b0, 8'h00, 9'h003, 8'h00, 8'h00, 8'h20,
         mk(1'b0, 1'b0, 8'h00, 1'b0, 1'b0, 1'b1, 11'h203, 1'b1), 1'b1);
    // Mid-run reset must also clear the pending dropped slot
    sys_rst_i = 1'b1;
    step(BOE_OP_OR_LITERAL_ACCUM, 1'b0, 8'h0F, 9'h000, 8'h00, 8'h30, 8'h00, '0, 1'b0);
    sys_rst_i = 1'b0;
    fop(BOE_OP_CLEAR_FILE_REG, 1'b1, 8'h77, 8'h00, 1'b1, 1'b1, 1'b0);
    $display("test reset done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge mclk_i);
    sys_rst_i = 1'b0;
    t_byte_ops();
    t_skips();
    t_or_jump();
    t_reset();
    tally_and_finish();
  end
  // Run limit in case the clock or a task stalls
  initial begin
    #100000;
    fail_count++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
